// >>> test/engine_model.sv
// Behavioural protocol engine: FIFO levels, event pulses, enable
`timescale 1ns/1ns
module engine_model (
  // Clock
  input  wire logic   clock_in,
  // Toward the block
  output logic [8:0]  rx_level_out,
  output logic [8:0]  tx_level_out,
  output logic [5:0]  evt_out,
  output logic [31:0] cause_out,
  output logic        enable_out
);
  initial begin
    rx_level_out = 9'h000;
    tx_level_out = 9'h000;
    evt_out      = 6'h00;
    cause_out    = 32'h0000_0000;
    enable_out   = 1'b1;
  end
  // Cause only counts with the pulse, so it is scrambled afterwards
  task automatic pulse(input int idx, input logic [31:0] cause);
    logic [5:0] v;
    v = 6'h00;
    v[idx] = 1'b1;
    @(posedge clock_in);
    evt_out      <= v;
    cause_out    <= cause;
    @(posedge clock_in);
    evt_out   <= 6'h00;
    cause_out <= ~cause;
  endtask
  task automatic levels(input logic [8:0] rx, input logic [8:0] tx);
    @(posedge clock_in);
    rx_level_out <= rx;
    tx_level_out <= tx;
  endtask
  task automatic set_enable(input logic en);
    @(posedge clock_in);
    enable_out <= en;
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the threshold and interrupt clear block
`timescale 1ns/1ns
module tb_top;
  import thr_irq_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0]  wstrb_in = 4'h0;
  logic        awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, tx_fifo_flush_out, irq_out;
  logic [1:0]  bresp_out, rresp_out;
  logic [31:0] rdata_out, tx_abort_source_out, cause;
  logic [8:0]  raw_interrupt_status_out, rx_lvl, tx_lvl;
  logic [7:0]  rx_fifo_threshold_out, tx_fifo_threshold_out;
  logic [5:0]  evt;
  logic        enable;
  int          failures = 0;
  int          samples_checked = 0;

  always #5 clock_in = ~clock_in;

  engine_model engine (.clock_in, .rx_level_out(rx_lvl), .tx_level_out(tx_lvl), .evt_out(evt),
                       .cause_out(cause), .enable_out(enable));

  i2c_fifo_threshold_irq_clear DUT (.clock_in, .rst_b_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
    .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .rx_fifo_level_in(rx_lvl), .tx_fifo_level_in(tx_lvl), .rx_underflow_evt_in(evt[0]),
    .rx_overflow_evt_in(evt[1]), .tx_overflow_evt_in(evt[2]), .read_request_evt_in(evt[3]),
    .tx_abort_evt_in(evt[4]), .tx_abort_cause_in(cause), .bus_activity_evt_in(evt[5]),
    .ctrl_enable_in(enable), .raw_interrupt_status_out, .tx_abort_source_out, .tx_fifo_flush_out,
    .rx_fifo_threshold_out, .tx_fifo_threshold_out, .irq_out);

  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is a flop output, so the value at the falling edge is the one the next rising edge samples
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ap, wp, a_go, w_go;
    @(posedge clock_in);
    ap = 1'b1;
    wp = 1'b1;
    resp = 2'h1;
    awaddr_in <= a;
    wdata_in <= d;
    wstrb_in <= 4'hF;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    for (n = 0; n < 40 && (ap || wp); n++) begin
      @(negedge clock_in);
      a_go = ap && awready_out;
      w_go = wp && wready_out;
      @(posedge clock_in);
      if (a_go) begin
        awvalid_in <= 1'b0;
        ap = 1'b0;
      end
      if (w_go) begin
        wvalid_in <= 1'b0;
        wp = 1'b0;
      end
    end
    for (n = 0; n < 40 && resp === 2'h1; n++) begin
      @(negedge clock_in);
      if (bvalid_out === 1'b1) resp = bresp_out;
      @(posedge clock_in);
    end
    bready_in <= 1'b0;
    if (ap || wp || resp === 2'h1) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic go, got;
    @(posedge clock_in);
    go = 1'b0;
    got = 1'b0;
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    for (n = 0; n < 40 && !go; n++) begin
      @(negedge clock_in);
      go = arready_out;
      @(posedge clock_in);
    end
    arvalid_in <= 1'b0;
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge clock_in);
      got = rvalid_out;
      d = rdata_out;
      resp = rresp_out;
      @(posedge clock_in);
    end
    rready_in <= 1'b0;
    if (!go || !got) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write response", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(what, d, exp);
  endtask

  // Flags and interrupt lag their causes by up to three cycles
  task automatic settle();
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  task automatic raw_is(input string what, input logic [8:0] exp);
    settle();
    check(what, 32'(raw_interrupt_status_out), 32'(exp));
  endtask

  task automatic reset_values();
    logic [7:0] regs [8];
    regs = '{RX_THR_OFF, TX_THR_OFF, CLR_ALL_OFF, CLR_RXU_OFF, CLR_RXO_OFF, CLR_TXO_OFF, CLR_RRQ_OFF, CLR_ABT_OFF};
    foreach (regs[i]) rd_chk("reset value", regs[i], 32'h0);
  endtask

  task automatic thresholds();
    wr(RX_THR_OFF, 32'h0000_0020);
    rd_chk("rx threshold clamp", RX_THR_OFF, 32'(FIFO_DEPTH));
    check("rx threshold out", 32'(rx_fifo_threshold_out), 32'(FIFO_DEPTH));
    wr(TX_THR_OFF, 32'hFFFF_FFFF);
    rd_chk("tx threshold clamp", TX_THR_OFF, 32'(FIFO_DEPTH));
    check("tx threshold out", 32'(tx_fifo_threshold_out), 32'(FIFO_DEPTH));
    wr(RX_THR_OFF, 32'h3);
    wr(TX_THR_OFF, 32'h3);
    engine.levels(9'h003, 9'h003);
    raw_is("level at both thresholds", 9'h000);
    engine.levels(9'h004, 9'h002);
    raw_is("rx above, tx below", 9'h014);
    wr(RX_THR_OFF, 32'h0);
    wr(TX_THR_OFF, 32'h0);
    engine.levels(9'h000, 9'h000);
    raw_is("zero thresholds, empty", 9'h000);
    engine.levels(9'h001, 9'h000);
    raw_is("zero rx threshold, one entry", 9'h004);
    engine.levels(9'h000, 9'h000);
  endtask

  task automatic single_clears();
    logic [7:0] offs [5];
    logic [8:0] bits [5];
    offs = '{CLR_RXU_OFF, CLR_RXO_OFF, CLR_TXO_OFF, CLR_RRQ_OFF, CLR_ABT_OFF};
    bits = '{9'h001, 9'h002, 9'h008, 9'h020, 9'h040};
    for (int i = 0; i < 5; i++) begin
      engine.pulse(i, 32'h0000_0005);
      wr(offs[i], 32'hFFFF_FFFF);
      raw_is("flag after write", bits[i]);
      if (i == 4) check("abort state", {tx_fifo_flush_out, tx_abort_source_out[30:0]}, 32'h8000_0005);
      rd_chk("clear read", offs[i], 32'h1);
      raw_is("flag after clear", 9'h000);
      check("abort released", {tx_fifo_flush_out, tx_abort_source_out[30:0]}, 32'h0);
      rd_chk("second clear read", offs[i], 32'h0);
    end
  endtask

  task automatic irq_and_global();
    wr(IRQ_STAT_OFF, 32'h1FF);
    wr(IRQ_MASK_OFF, 32'h1FF);
    engine.pulse(1, 32'h0);
    settle();
    check("irq raised", 32'(irq_out), 32'h1);
    wr(IRQ_MASK_OFF, 32'h0);
    settle();
    check("irq masked", 32'(irq_out), 32'h0);
    wr(IRQ_STAT_OFF, 32'h1FF);
    wr(IRQ_MASK_OFF, 32'h1FF);
    settle();
    check("irq status cleared", 32'(irq_out), 32'h0);
    for (int i = 0; i < 6; i++) engine.pulse(i, 32'h0000_00A0);
    engine.levels(9'h005, 9'h000);
    raw_is("all flags set", 9'h16F);
    rd_chk("global clear read", CLR_ALL_OFF, 32'h1);
    raw_is("hardware flag kept", 9'h004);
    check("global abort clear", {irq_out, tx_fifo_flush_out, tx_abort_source_out[29:0]}, 32'h0);
    engine.levels(9'h000, 9'h000);
  endtask

  task automatic activity();
    logic [31:0] d;
    logic [1:0]  r;
    engine.pulse(5, 32'h0);
    raw_is("activity sticky", 9'h100);
    engine.set_enable(1'b0);
    raw_is("activity disable", 9'h000);
    engine.set_enable(1'b1);
    engine.pulse(5, 32'h0);
    rd_chk("activity clear read", CLR_ACT_OFF, 32'h1);
    raw_is("activity cleared", 9'h000);
    axi_read(8'hF0, d, r);
    check("unmapped read", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axi_write(8'hF0, 32'h1, r);
    check("unmapped write", 32'(r), 32'(RESP_SLVERR));
  endtask

  initial begin
    repeat (10) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    reset_values();
    thresholds();
    single_clears();
    irq_and_global();
    activity();
    wrap_up();
  end
endmodule

// >>> verilog/flag_bank.sv
// Sticky raw flags, abort source bits and transmit FIFO flush hold
`timescale 1ns/1ns
module flag_bank
  import thr_irq_pkg::*;
(
  // Clock and reset
  input wire logic   clock_in,
  input wire logic   rst_b_in,
  // Flag traffic
  flag_bank_if.bank  fb
);
  logic [31:0] src_r;
  logic        flush_r;

  genvar i;
  generate
    for (i = 0; i < FLAG_W; i = i + 1) begin : g_flag
      if (STICKY_MASK[i]) begin : g_sticky
        logic bit_r;
        // Set wins over a clear in the same cycle
        always_ff @(posedge clock_in or negedge rst_b_in) begin
          if (!rst_b_in) begin
            bit_r <= 1'b0;
          end else begin
            bit_r <= fb.set[i] | (bit_r & ~fb.clr[i]); // see RULE16
          end
        end
        assign fb.flags[i] = bit_r;
      end else begin : g_level
        assign fb.flags[i] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_r   <= 32'h0000_0000;
      flush_r <= 1'b0;
    end else begin
      src_r   <= fb.src_set | (src_r & ~{32{fb.src_clr}}); // see RULE13
      flush_r <= fb.set[BIT_TX_ABORT] | (flush_r & ~fb.src_clr); // see RULE14
    end
  end

  assign fb.src   = src_r;
  assign fb.flush = flush_r;
endmodule

// >>> verilog/flag_bank_if.sv
// Carrier between the bus top and the sticky flag bank
`timescale 1ns/1ns
interface flag_bank_if;
  logic [8:0]  set;
  logic [8:0]  clr;
  logic [8:0]  flags;
  logic [31:0] src_set;
  logic        src_clr;
  logic [31:0] src;
  logic        flush;
  modport bank  (input set, input clr, input src_set, input src_clr, output flags, output src, output flush);
  modport owner (output set, output clr, output src_set, output src_clr, input flags, input src, input flush);
endinterface

// >>> verilog/i2c_fifo_threshold_irq_clear.sv
// FIFO thresholds, read-to-clear interrupt registers and AXI4-Lite slave
// Operation
// (RULE1) Receive full flag, raw bit 2, set while receive level exceeds threshold.
// (RULE2) Receive threshold writes above FIFO depth store the depth instead.
// (RULE3) Receive threshold means value plus one entries.
// (RULE4) Transmit empty flag, raw bit 4, set while transmit level below threshold.
// (RULE5) Transmit threshold writes above FIFO depth store the depth instead.
// (RULE6) Transmit threshold counts entries directly.
// (RULE7) Reading 0x40 clears combined interrupt, software flags and abort source.
// (RULE8) Reading 0x40 leaves hardware-cleared flags alone.
// (RULE9) Reading 0x44 clears receive underflow flag, bit 0.
// (RULE10) Reading 0x48 clears receive overflow flag, bit 1.
// (RULE11) Reading 0x4C clears transmit overflow flag, bit 3.
// (RULE12) Reading 0x50 clears read request flag, bit 5.
// (RULE13) Reading 0x54 clears abort flag, bit 6, and abort source.
// (RULE14) Reading 0x54 also releases the transmit FIFO from flush.
// (RULE15) Thresholds and clear registers read zero after reset.
// (RULE16) Activity flag, bit 8, sticky; cleared by clears, disable or reset.
// (RULE17) Clear registers return pre-clear flag in bit 0; writes ignored.
`timescale 1ns/1ns
module i2c_fifo_threshold_irq_clear
  import thr_irq_pkg::*;
(
  // Clock and reset
  input  wire logic [0:0]          clock_in,
  input  wire logic                rst_b_in,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   awaddr_in,
  input  wire logic                awvalid_in,
  output logic                     awready_out,
  input  wire logic [DATA_W-1:0]   wdata_in,
  input  wire logic [3:0]          wstrb_in,
  input  wire logic                wvalid_in,
  output logic                     wready_out,
  // AXI4-Lite write response
  output logic [1:0]               bresp_out,
  output logic                     bvalid_out,
  input  wire logic                bready_in,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   araddr_in,
  input  wire logic                arvalid_in,
  output logic                     arready_out,
  output logic [DATA_W-1:0]        rdata_out,
  output logic [1:0]               rresp_out,
  output logic                     rvalid_out,
  input  wire logic                rready_in,
  // Protocol engine levels and events
  input  wire logic [LEVEL_W-1:0]  rx_fifo_level_in,
  input  wire logic [LEVEL_W-1:0]  tx_fifo_level_in,
  input  wire logic                rx_underflow_evt_in,
  input  wire logic                rx_overflow_evt_in,
  input  wire logic                tx_overflow_evt_in,
  input  wire logic                read_request_evt_in,
  input  wire logic                tx_abort_evt_in,
  input  wire logic [DATA_W-1:0]   tx_abort_cause_in,
  input  wire logic                bus_activity_evt_in,
  input  wire logic                ctrl_enable_in,
  // Status toward the engine and CPU
  output logic [FLAG_W-1:0]        raw_interrupt_status_out,
  output logic [DATA_W-1:0]        tx_abort_source_out,
  output logic                     tx_fifo_flush_out,
  output logic [THR_W-1:0]         rx_fifo_threshold_out,
  output logic [THR_W-1:0]         tx_fifo_threshold_out,
  output logic                     irq_out
);
  // Address match, shared by read and write decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    addr_hit = (addr == off);
  endfunction

  // Depth clamp for both thresholds
  function automatic logic [THR_W-1:0] clamp_depth(input logic [THR_W-1:0] val);
    clamp_depth = (val > FIFO_DEPTH) ? FIFO_DEPTH : val;
  endfunction

  flag_bank_if fb ();

  logic                awready_r;
  logic                wready_r;
  logic                aw_have_r;
  logic                w_have_r;
  logic [ADDR_W-1:0]   aw_addr_r;
  logic [DATA_W-1:0]   w_data_r;
  logic [3:0]          w_strb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [1:0]          rresp_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                rd_known;
  logic [THR_W-1:0]    rx_thr_r;
  logic [THR_W-1:0]    tx_thr_r;
  logic                rx_full_r;
  logic                tx_empty_r;
  logic [FLAG_W-1:0]   raw_prev_r;
  logic [FLAG_W-1:0]   irq_status_r;
  logic [FLAG_W-1:0]   irq_mask_r;
  logic                irq_r;

  // Handshakes
  wire aw_fire = awvalid_in & awready_r;
  wire w_fire  = wvalid_in & wready_r;
  wire ar_fire = arvalid_in & arready_r;
  wire b_done  = bvalid_r & bready_in;
  wire r_done  = rvalid_r & rready_in;
  wire wr_do   = aw_have_r & w_have_r & ~bvalid_r;

  // Write decode
  wire wr_rx_thr  = wr_do & addr_hit(aw_addr_r, RX_THR_OFF) & w_strb_r[0];
  wire wr_tx_thr  = wr_do & addr_hit(aw_addr_r, TX_THR_OFF) & w_strb_r[0];
  wire wr_irq_st  = wr_do & addr_hit(aw_addr_r, IRQ_STAT_OFF);
  wire wr_irq_msk = wr_do & addr_hit(aw_addr_r, IRQ_MASK_OFF);
  // Clear registers accept writes silently
  wire wr_known   = addr_hit(aw_addr_r, RX_THR_OFF) | addr_hit(aw_addr_r, TX_THR_OFF) |
                    addr_hit(aw_addr_r, IRQ_STAT_OFF) | addr_hit(aw_addr_r, IRQ_MASK_OFF) |
                    addr_hit(aw_addr_r, RAW_STAT_OFF) | addr_hit(aw_addr_r, ABT_SRC_OFF) |
                    addr_hit(aw_addr_r, CLR_ALL_OFF) | addr_hit(aw_addr_r, CLR_RXU_OFF) |
                    addr_hit(aw_addr_r, CLR_RXO_OFF) | addr_hit(aw_addr_r, CLR_TXO_OFF) |
                    addr_hit(aw_addr_r, CLR_RRQ_OFF) | addr_hit(aw_addr_r, CLR_ABT_OFF) |
                    addr_hit(aw_addr_r, CLR_ACT_OFF); // see RULE17

  // Read-side clear strobes, taken at the address handshake
  wire clr_all = ar_fire & addr_hit(araddr_in, CLR_ALL_OFF); // see RULE7
  wire clr_rxu = ar_fire & addr_hit(araddr_in, CLR_RXU_OFF); // see RULE9
  wire clr_rxo = ar_fire & addr_hit(araddr_in, CLR_RXO_OFF); // see RULE10
  wire clr_txo = ar_fire & addr_hit(araddr_in, CLR_TXO_OFF); // see RULE11
  wire clr_rrq = ar_fire & addr_hit(araddr_in, CLR_RRQ_OFF); // see RULE12
  wire clr_abt = ar_fire & addr_hit(araddr_in, CLR_ABT_OFF); // see RULE13
  wire clr_act = ar_fire & addr_hit(araddr_in, CLR_ACT_OFF);

  wire [FLAG_W-1:0] raw_status = {fb.flags[8], 1'b0, fb.flags[6:5], tx_empty_r, fb.flags[3], rx_full_r, fb.flags[1:0]};
  wire [FLAG_W-1:0] raw_rise   = raw_status & ~raw_prev_r;

  // Sticky flag sets and clears; hardware level flags never see a clear
  assign fb.set = {bus_activity_evt_in, 1'b0, tx_abort_evt_in, read_request_evt_in, 1'b0,
                   tx_overflow_evt_in, 1'b0, rx_overflow_evt_in, rx_underflow_evt_in};
  assign fb.clr = ({FLAG_W{clr_all}} & STICKY_MASK) |
                  {clr_act | ~ctrl_enable_in, 1'b0, clr_abt, clr_rrq, 1'b0,
                   clr_txo, 1'b0, clr_rxo, clr_rxu}; // see RULE8, see RULE16
  assign fb.src_set = tx_abort_evt_in ? tx_abort_cause_in : 32'h0000_0000;
  assign fb.src_clr = clr_all | clr_abt; // see RULE7, see RULE14

  flag_bank u_flag_bank (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .fb       (fb)
  );

  // Write channel
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_r <= awaddr_in;
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_fire) begin
        w_data_r <= wdata_in;
        w_strb_r <= wstrb_in;
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_r  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Threshold registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_thr_r <= THR_RST; // see RULE15
      tx_thr_r <= THR_RST;
    end else begin
      if (wr_rx_thr) begin
        rx_thr_r <= clamp_depth(w_data_r[THR_W-1:0]); // see RULE2
      end
      if (wr_tx_thr) begin
        tx_thr_r <= clamp_depth(w_data_r[THR_W-1:0]); // see RULE5
      end
    end
  end

  // Level flags follow the FIFOs; only hardware clears them
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_full_r  <= 1'b0;
      tx_empty_r <= 1'b0;
    end else begin
      rx_full_r  <= rx_fifo_level_in > {1'b0, rx_thr_r}; // see RULE1, see RULE3
      tx_empty_r <= tx_fifo_level_in < {1'b0, tx_thr_r}; // see RULE4, see RULE6
    end
  end

  // Interrupt status and mask; set wins over clear
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raw_prev_r   <= '0;
      irq_status_r <= '0;
      irq_mask_r   <= MASK_RST;
      irq_r        <= 1'b0;
    end else begin
      raw_prev_r   <= raw_status;
      irq_status_r <= raw_rise | (irq_status_r &
                      ~({FLAG_W{wr_irq_st}} & w_data_r[FLAG_W-1:0]) & ~{FLAG_W{clr_all}}); // see RULE7
      if (wr_irq_msk) begin
        irq_mask_r <= w_data_r[FLAG_W-1:0];
      end
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // Read mux; clear registers show the flag as it was before the clear
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rd_known  = 1'b1;
    if (addr_hit(araddr_in, RX_THR_OFF)) begin
      rdata_nxt[THR_W-1:0] = rx_thr_r;
    end else if (addr_hit(araddr_in, TX_THR_OFF)) begin
      rdata_nxt[THR_W-1:0] = tx_thr_r;
    end else if (addr_hit(araddr_in, CLR_ALL_OFF)) begin
      rdata_nxt[0] = irq_r;
    end else if (addr_hit(araddr_in, CLR_RXU_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_RX_UNDER]; // see RULE17
    end else if (addr_hit(araddr_in, CLR_RXO_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_RX_OVER];
    end else if (addr_hit(araddr_in, CLR_TXO_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_TX_OVER];
    end else if (addr_hit(araddr_in, CLR_RRQ_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_READ_REQ];
    end else if (addr_hit(araddr_in, CLR_ABT_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_TX_ABORT];
    end else if (addr_hit(araddr_in, CLR_ACT_OFF)) begin
      rdata_nxt[0] = raw_status[BIT_ACTIVITY];
    end else if (addr_hit(araddr_in, RAW_STAT_OFF)) begin
      rdata_nxt[FLAG_W-1:0] = raw_status;
    end else if (addr_hit(araddr_in, ABT_SRC_OFF)) begin
      rdata_nxt = fb.src;
    end else if (addr_hit(araddr_in, IRQ_STAT_OFF)) begin
      rdata_nxt[FLAG_W-1:0] = irq_status_r;
    end else if (addr_hit(araddr_in, IRQ_MASK_OFF)) begin
      rdata_nxt[FLAG_W-1:0] = irq_mask_r;
    end else begin
      rd_known = 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rdata_nxt;
        rresp_r   <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (r_done) begin
        arready_r <= 1'b1;
        rvalid_r  <= 1'b0;
      end
    end
  end

  assign awready_out              = awready_r;
  assign wready_out               = wready_r;
  assign bvalid_out               = bvalid_r;
  assign bresp_out                = bresp_r;
  assign arready_out              = arready_r;
  assign rvalid_out               = rvalid_r;
  assign rresp_out                = rresp_r;
  assign rdata_out                = rdata_r;
  assign raw_interrupt_status_out = raw_status;
  assign tx_abort_source_out      = fb.src;
  assign tx_fifo_flush_out        = fb.flush;
  assign rx_fifo_threshold_out    = rx_thr_r;
  assign tx_fifo_threshold_out    = tx_thr_r;
  assign irq_out                  = irq_r;

  // Checks
  chk_rx_full_level: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE1
    1'b1 |=> rx_full_r == ($past(rx_fifo_level_in) > {1'b0, $past(rx_thr_r)}))
    else $error("receive full flag disagrees with level");

  chk_rx_thr_clamp: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE2
    wr_rx_thr && (w_data_r[7:0] > FIFO_DEPTH) |=> rx_thr_r == FIFO_DEPTH)
    else $error("receive threshold not clamped");

  chk_tx_thr_clamp: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE5
    wr_tx_thr |=> tx_thr_r == (($past(w_data_r[7:0]) > FIFO_DEPTH) ? FIFO_DEPTH : $past(w_data_r[7:0])))
    else $error("transmit threshold not stored or clamped");

  chk_tx_empty_level: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE4
    $stable(tx_fifo_level_in) && $stable(tx_thr_r)
    |=> tx_empty_r == ($past(tx_fifo_level_in) < {1'b0, $past(tx_thr_r)}))
    else $error("transmit empty flag disagrees with level");

  chk_global_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE7
    clr_all && (fb.set == 9'h000) && !tx_abort_evt_in && (raw_rise == 9'h000)
    |=> ((raw_status & STICKY_MASK) == 9'h000) && (fb.src == 32'h0000_0000) && (irq_status_r == 9'h000)
    ##1 !irq_r)
    else $error("global clear left a flag set");

  chk_hw_flags_kept: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE8
    clr_all && $stable(rx_fifo_level_in) && $stable(rx_thr_r) && $past(clr_all) == 1'b0
    |=> rx_full_r == $past(rx_full_r))
    else $error("global clear touched a level flag");

  chk_abort_release: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE14
    clr_abt && !tx_abort_evt_in |=> !tx_fifo_flush_out && (tx_abort_source_out == 32'h0000_0000))
    else $error("abort clear did not release transmit FIFO");

  chk_clear_readback: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE17
    clr_rxu |=> rvalid_r && (rdata_r == {31'h0000_0000, $past(raw_status[BIT_RX_UNDER])}))
    else $error("clear register returned wrong value");

  chk_activity_disable: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE16
    !ctrl_enable_in && !bus_activity_evt_in |=> !raw_status[BIT_ACTIVITY])
    else $error("activity flag survived disable");

  chk_overflow_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in) // see RULE10
    clr_rxo && !rx_overflow_evt_in |=> !raw_status[BIT_RX_OVER])
    else $error("receive overflow flag not cleared");
endmodule

// >>> verilog/thr_irq_pkg.sv
// Constants for the FIFO threshold and interrupt clear block
package thr_irq_pkg;
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 8;
  localparam int          THR_W          = 8;
  localparam int          LEVEL_W        = 9;
  localparam int          FLAG_W         = 9;
  // FIFO depth is not fixed by the map; plain default
  localparam logic [7:0]  FIFO_DEPTH     = 8'h10;
  localparam logic [7:0]  THR_RST        = 8'h00;
  localparam logic [8:0]  MASK_RST       = 9'h000;
  // Register byte offsets
  localparam logic [7:0]  RX_THR_OFF     = 8'h38;
  localparam logic [7:0]  TX_THR_OFF     = 8'h3C;
  localparam logic [7:0]  CLR_ALL_OFF    = 8'h40;
  localparam logic [7:0]  CLR_RXU_OFF    = 8'h44;
  localparam logic [7:0]  CLR_RXO_OFF    = 8'h48;
  localparam logic [7:0]  CLR_TXO_OFF    = 8'h4C;
  localparam logic [7:0]  CLR_RRQ_OFF    = 8'h50;
  localparam logic [7:0]  CLR_ABT_OFF    = 8'h54;
  localparam logic [7:0]  CLR_ACT_OFF    = 8'h5C;
  localparam logic [7:0]  RAW_STAT_OFF   = 8'h80;
  localparam logic [7:0]  ABT_SRC_OFF    = 8'h84;
  localparam logic [7:0]  IRQ_STAT_OFF   = 8'h88;
  localparam logic [7:0]  IRQ_MASK_OFF   = 8'h8C;
  // Raw status bit positions
  localparam int          BIT_RX_UNDER   = 0;
  localparam int          BIT_RX_OVER    = 1;
  localparam int          BIT_RX_FULL    = 2;
  localparam int          BIT_TX_OVER    = 3;
  localparam int          BIT_TX_EMPTY   = 4;
  localparam int          BIT_READ_REQ   = 5;
  localparam int          BIT_TX_ABORT   = 6;
  localparam int          BIT_ACTIVITY   = 8;
  // Flags held sticky and cleared by software reads
  localparam logic [8:0]  STICKY_MASK    = 9'h16B;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage
